// ===== rtl/pvp_top.sv
// Purpose: parallel video port with wishbone registers and memory channel
// Assumes: port_sample_clock at most half of clk_i, sampled by clk_i
// Notes:   all port logic runs on clk_i, advanced on sampled clock edges
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module pvp_top
  import pvp_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // port pins
  input  wire logic        port_sample_clock_i,
  input  wire logic [2:0]  frame_sync_i,
  output logic [2:0]       frame_sync_o,
  output logic [2:0]       frame_sync_oe_o,
  input  wire logic [15:0] port_data_i,
  output logic [15:0]      port_data_o,
  output logic             port_data_oe_o,
  // memory side
  output logic             mem_wr_valid_o,
  output logic [15:0]      mem_wr_data_o,
  input  wire logic        mem_wr_ready_i,
  input  wire logic        mem_rd_valid_i,
  input  wire logic [15:0] mem_rd_data_i,
  output logic             mem_rd_ready_o
);
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_WAIT  = 5'b00010,
    ST_DELAY = 5'b00100,
    ST_XFER  = 5'b01000,
    ST_DONE  = 5'b10000
  } pvp_state_e;

  pvp_dma_if dma ();

  logic [31:0] ctrl_q;
  logic [15:0] delay_q;
  logic [15:0] count_q;
  logic        ack_q;
  logic [31:0] rdata_d;
  logic        overrun_q;
  pvp_state_e  st_q;
  logic [15:0] cnt_q;
  logic [15:0] lines_q;
  logic [15:0] hpos_q;
  logic [15:0] rx_q;
  logic        rx_valid_q;
  logic [15:0] tx_q;

  // synchronised pins
  logic        clk_s1_q, clk_s2_q, clk_s3_q;
  logic [2:0]  fs_s1_q, fs_s2_q;
  logic [15:0] dat_s1_q, dat_s2_q;
  logic        fs1_prev_q;

  // preamble decoder state
  logic [1:0]  trc_q;
  logic        in_trc_q;
  logic        field_q, vblank_q, hblank_q;
  logic        synced_q;

  wire         en     = ctrl_q[PVP_EN_BIT];
  wire [2:0]   mode   = ctrl_q[PVP_MODE_LSB +: 3];
  wire [2:0]   wsel   = ctrl_q[PVP_WIDTH_LSB +: 3];
  wire [1:0]   nsync  = ctrl_q[PVP_NSYNC_LSB +: 2];
  wire [15:0]  wmask  = pvp_width_mask(wsel);
  wire         video  = (mode >= PVP_M_ACTIVE);
  wire         is_out = (mode == PVP_M_OUTPUT);
  // port clock pin also clocks external timers; only its rising edge is used here
  wire         pedge  = clk_s2_q && !clk_s3_q;
  wire         fs1_re = fs_s2_q[0] && !fs1_prev_q;

  // edges are found by sampling, so the port clock must stay below half of clk_i
  always_ff @(posedge clk_i) begin
    clk_s1_q   <= port_sample_clock_i;
    clk_s2_q   <= clk_s1_q;
    clk_s3_q   <= clk_s2_q;
    fs_s1_q    <= frame_sync_i;
    fs_s2_q    <= fs_s1_q;
    dat_s1_q   <= port_data_i;
    dat_s2_q   <= dat_s1_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fs1_prev_q <= 1'b0;
    end else if (pedge) begin
      fs1_prev_q <= fs_s2_q[0];
    end
  end

  // register bus
  wire wb_req = wb_cyc_i && wb_stb_i && !ack_q;
  wire wb_wr  = wb_req && wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req;
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q  <= PVP_CTRL_RST;
      delay_q <= PVP_DELAY_RST;
      count_q <= PVP_COUNT_RST;
    end else if (wb_wr) begin
      case (wb_adr_i)
        PVP_CTRL_OFF:  ctrl_q  <= merge(ctrl_q, wb_dat_i, wb_sel_i) & 32'h0000_01FF;
        PVP_DELAY_OFF: delay_q <= 16'(merge({16'h0000, delay_q}, wb_dat_i, wb_sel_i));
        PVP_COUNT_OFF: count_q <= 16'(merge({16'h0000, count_q}, wb_dat_i, wb_sel_i));
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    case (wb_adr_i)
      PVP_CTRL_OFF:   rdata_d = ctrl_q;
      PVP_DELAY_OFF:  rdata_d = {16'h0000, delay_q};
      PVP_COUNT_OFF:  rdata_d = {16'h0000, count_q};
      PVP_STATUS_OFF: rdata_d = {23'h000000, overrun_q, synced_q, field_q, vblank_q, st_q};
      PVP_RXDATA_OFF: rdata_d = {16'h0000, rx_q};
      default:        rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req) begin
      wb_dat_o <= rdata_d;
    end
  end
  assign wb_ack_o = ack_q;

  // preamble decoder: ones, zero, zero, then status word
  wire [9:0] vw    = dat_s2_q[9:0] & wmask[9:0];
  wire       w8    = (wsel == 3'h0);
  wire       ones  = w8 ? (vw[7:0] == PVP_TRC_ONES[7:0]) : (vw == PVP_TRC_ONES);
  wire       zero  = w8 ? (vw[7:0] == PVP_TRC_ZERO[7:0]) : (vw == PVP_TRC_ZERO);
  wire [2:0] fvh   = w8 ? vw[6:4] : vw[8:6];
  wire       stat  = video && pedge && (trc_q == 2'd3);

  always_ff @(posedge clk_i) begin
    if (rst_i || !video) begin
      trc_q <= 2'd0;
    end else if (pedge) begin
      case (trc_q)
        2'd0:    trc_q <= ones ? 2'd1 : 2'd0;
        2'd1:    trc_q <= zero ? 2'd2 : (ones ? 2'd1 : 2'd0);
        2'd2:    trc_q <= zero ? 2'd3 : 2'd0;
        default: trc_q <= 2'd0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !video) begin
      field_q  <= 1'b0;
      vblank_q <= 1'b1;
      hblank_q <= 1'b1;
    end else if (stat) begin
      field_q  <= fvh[2];
      vblank_q <= fvh[1];
      hblank_q <= fvh[0];
    end
  end

  // the word now on the pins belongs to a code; judged before sampling so the
  // all-ones word itself never leaks through in the active and vertical-blank submodes
  always_comb begin
    in_trc_q = video && ((trc_q == 2'd0 && ones) || trc_q != 2'd0);
  end

  // field one begins at a status word with field bit clear after a field-two word, or at the first such word while not yet synced
  wire sof = stat && !fvh[2] && (field_q || !synced_q);
  wire sav = stat && !fvh[0];

  always_ff @(posedge clk_i) begin
    if (rst_i || !en || !video) begin
      synced_q <= 1'b0;
    end else if (sof) begin
      synced_q <= 1'b1;
    end
  end

  // main sequencer
  wire sample = pedge && st_q == ST_XFER && dma.req;
  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 16'h0000;
      lines_q <= 16'h0000;
    end else begin
      case (st_q)
        ST_IDLE: st_q <= ST_WAIT;
        ST_WAIT: begin
          if (pedge && mode == PVP_M_INPUT && fs1_re) begin
            st_q  <= (delay_q == 16'h0000) ? ST_XFER : ST_DELAY;
            cnt_q <= delay_q;
          end else if (mode == PVP_M_CAPTURE || is_out) begin
            st_q  <= ST_XFER;
            cnt_q <= 16'h0000;
          end else if (video && sof) begin
            st_q    <= ST_XFER;
            lines_q <= 16'h0000;
          end
        end
        ST_DELAY: begin
          if (pedge) begin
            cnt_q <= cnt_q - 16'h0001;
            if (cnt_q == 16'h0001) begin
              st_q  <= ST_XFER;
              cnt_q <= 16'h0000;
            end
          end
        end
        ST_XFER: begin
          if (mode == PVP_M_INPUT && sample) begin
            cnt_q <= cnt_q + 16'h0001;
            if (cnt_q + 16'h0001 >= count_q) begin
              st_q <= ST_WAIT;
            end
          end else if (mode == PVP_M_ACTIVE && stat && fvh[0] && !hblank_q && !vblank_q) begin
            lines_q <= lines_q + 16'h0001;
            if (lines_q + 16'h0001 >= count_q) begin
              st_q <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          if (sof) begin
            st_q    <= ST_XFER;
            lines_q <= 16'h0000;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // receive path, gated per submode
  logic keep;
  always_comb begin
    case (mode)
      PVP_M_INPUT, PVP_M_CAPTURE: keep = 1'b1;
      PVP_M_ACTIVE: keep = synced_q && !vblank_q && !hblank_q && !in_trc_q;
      PVP_M_VBLANK: keep = synced_q && vblank_q && !in_trc_q;
      PVP_M_FIELD:  keep = synced_q;
      default:      keep = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_valid_q <= 1'b0;
      rx_q       <= 16'h0000;
    end else begin
      rx_valid_q <= 1'b0;
      if (sample && !is_out && keep && !(mode == PVP_M_ACTIVE && sav)) begin
        rx_valid_q <= 1'b1;
        rx_q       <= dat_s2_q & (video ? {6'h00, (w8 ? 10'h0FF : 10'h3FF)} : wmask);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      overrun_q <= 1'b0;
    end else if (pedge && st_q == ST_XFER && !is_out && !dma.req) begin
      overrun_q <= 1'b1;
    end
  end

  assign dma.rx_valid = rx_valid_q;
  assign dma.rx_data  = rx_q;
  assign dma.tx_ready = pedge && is_out && st_q == ST_XFER;

  // frame-capture and output sync generator
  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      hpos_q <= 16'h0000;
    end else if (pedge && st_q == ST_XFER && (mode == PVP_M_CAPTURE || is_out)) begin
      hpos_q <= (hpos_q == PVP_LINE_LEN - 16'h0001) ? 16'h0000 : hpos_q + 16'h0001;
    end
  end

  wire hs = hpos_q < PVP_HS_WIDTH;
  wire vs = (cnt_q == 16'h0000) && hs;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_sync_o <= 3'b000;
      tx_q         <= 16'h0000;
    end else begin
      frame_sync_o <= {vs && hs, vs, hs};
      if (dma.tx_ready && dma.tx_valid) begin
        tx_q <= dma.tx_data & wmask;
      end
    end
  end

  // pin directions by submode; sync one and two are timer-shared pins
  always_comb begin
    frame_sync_oe_o = 3'b000;
    port_data_oe_o  = 1'b0;
    if (en && mode == PVP_M_CAPTURE) begin
      frame_sync_oe_o = 3'b011;
    end else if (en && is_out) begin
      frame_sync_oe_o = (nsync == 2'd0) ? 3'b001 : ((nsync == 2'd1) ? 3'b011 : 3'b111);
      port_data_oe_o  = 1'b1;
    end
  end
  assign port_data_o = tx_q;

  pvp_dma_chan u_chan (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .core           (dma.chan),
    .mem_wr_valid_o (mem_wr_valid_o),
    .mem_wr_data_o  (mem_wr_data_o),
    .mem_wr_ready_i (mem_wr_ready_i),
    .mem_rd_valid_i (mem_rd_valid_i),
    .mem_rd_data_i  (mem_rd_data_i),
    .mem_rd_ready_o (mem_rd_ready_o)
  );
endmodule

// ===== rtl/pvp_pkg.sv
// Purpose: shared constants for the parallel video port
// Assumes: classic wishbone register access, 32-bit data
// Notes:   register offsets are byte addresses
package pvp_pkg;
  localparam int unsigned PVP_DW = 16;
  // register byte offsets
  localparam logic [7:0] PVP_CTRL_OFF   = 8'h00;
  localparam logic [7:0] PVP_DELAY_OFF  = 8'h04;
  localparam logic [7:0] PVP_COUNT_OFF  = 8'h08;
  localparam logic [7:0] PVP_STATUS_OFF = 8'h0C;
  localparam logic [7:0] PVP_TXDATA_OFF = 8'h10;
  localparam logic [7:0] PVP_RXDATA_OFF = 8'h14;
  // control field positions
  localparam int unsigned PVP_EN_BIT     = 0;
  localparam int unsigned PVP_MODE_LSB   = 1;   // 3 bits
  localparam int unsigned PVP_WIDTH_LSB  = 4;   // 3 bits: 0=8,1..6 = 10..15, 7=16
  localparam int unsigned PVP_NSYNC_LSB  = 7;   // 2 bits: frame syncs driven in output
  localparam logic [31:0] PVP_CTRL_RST   = 32'h0000_0080;
  localparam logic [15:0] PVP_DELAY_RST  = 16'h0000;
  localparam logic [15:0] PVP_COUNT_RST  = 16'h0000;
  // frame-capture line timing in port clock cycles
  localparam logic [15:0] PVP_LINE_LEN   = 16'h0040;
  localparam logic [15:0] PVP_HS_WIDTH   = 16'h0004;
  // timing reference code words (10-bit form, low 8 bits used for 8-bit)
  localparam logic [9:0]  PVP_TRC_ONES   = 10'h3FF;
  localparam logic [9:0]  PVP_TRC_ZERO   = 10'h000;

  typedef enum logic [2:0] {
    PVP_M_INPUT   = 3'h0,
    PVP_M_CAPTURE = 3'h1,
    PVP_M_OUTPUT  = 3'h2,
    PVP_M_ACTIVE  = 3'h3,
    PVP_M_VBLANK  = 3'h4,
    PVP_M_FIELD   = 3'h5
  } pvp_mode_e;

  function automatic logic [15:0] pvp_width_mask(input logic [2:0] w);
    logic [4:0] n;
    n = (w == 3'h0) ? 5'd8 : ((w == 3'h7) ? 5'd16 : 5'(w + 5'd9));
    pvp_width_mask = 16'((17'h1 << n) - 17'h1);
  endfunction
endpackage

// ===== rtl/pvp_dma_if.sv
// Purpose: word stream between the port core and the memory channel
// Assumes: single clock domain
// Notes:   valid/ready handshake, no buffering
`timescale 1ns/1ps
interface pvp_dma_if;
  logic        rx_valid;
  logic [15:0] rx_data;
  logic        tx_ready;
  logic [15:0] tx_data;
  logic        tx_valid;
  logic        req;
  modport core (output rx_valid, output rx_data, output tx_ready,
                input tx_data, input tx_valid, input req);
  modport chan (input rx_valid, input rx_data, input tx_ready,
                output tx_data, output tx_valid, output req);
endinterface

// ===== rtl/pvp_dma_chan.sv
// Purpose: autonomous memory channel for port words
// Assumes: memory side is a simple valid/ready stream
// Notes:   holds one word each way; stalls the core when memory writes stall
`timescale 1ns/1ps
module pvp_dma_chan (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // core side
  pvp_dma_if.chan          core,
  // memory side
  output logic             mem_wr_valid_o,
  output logic [15:0]      mem_wr_data_o,
  input  wire logic        mem_wr_ready_i,
  input  wire logic        mem_rd_valid_i,
  input  wire logic [15:0] mem_rd_data_i,
  output logic             mem_rd_ready_o
);
  logic        tx_full_q;
  logic [15:0] tx_q;
  logic        wr_full_q;
  logic [15:0] wr_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_full_q <= 1'b0;
      wr_q      <= 16'h0000;
    end else if (core.rx_valid && !wr_full_q) begin
      wr_full_q <= 1'b1;
      wr_q      <= core.rx_data;
    end else if (mem_wr_ready_i) begin
      wr_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_full_q <= 1'b0;
      tx_q      <= 16'h0000;
    end else if (!tx_full_q && mem_rd_valid_i) begin
      tx_full_q <= 1'b1;
      tx_q      <= mem_rd_data_i;
    end else if (core.tx_ready) begin
      tx_full_q <= 1'b0;
    end
  end

  assign mem_wr_valid_o = wr_full_q;
  assign mem_wr_data_o  = wr_q;
  assign mem_rd_ready_o = !tx_full_q;
  assign core.tx_valid  = tx_full_q;
  assign core.tx_data   = tx_q;
  // a full write slot stops sampling rather than drop a word
  assign core.req       = !wr_full_q;
endmodule

// ===== verification/pvp_top_asserts.sv
// Purpose: port-level checks for pvp_top
// Assumes: ack comes one cycle after a taken request
// Notes:   sees top ports only
`timescale 1ns/1ps
module pvp_top_asserts (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // pins and memory
  input wire logic [2:0]  frame_sync_oe_o,
  input wire logic        port_data_oe_o,
  input wire logic        mem_wr_valid_o,
  input wire logic [15:0] mem_wr_data_o,
  input wire logic        mem_wr_ready_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  property p_ack_after_req; req |-> ##1 wb_ack_o; endproperty
  a_ack_after_req: assert property (p_ack_after_req)
    else $error("request not answered next cycle");
  property p_ack_single; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_single: assert property (p_ack_single)
    else $error("ack longer than one cycle");
  property p_no_stray_ack; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  a_no_stray_ack: assert property (p_no_stray_ack)
    else $error("ack without request");
  property p_dat_holds; !req |=> $stable(wb_dat_o); endproperty
  a_dat_holds: assert property (p_dat_holds)
    else $error("read data moved between requests");
  property p_upper_zero; req && !wb_we_i |=> wb_dat_o[31:16] == 16'h0000; endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("read data above bit 15 not zero");
  property p_reset_quiet; $fell(rst_i) |-> frame_sync_oe_o == 3'h0 && !port_data_oe_o; endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("pins driven after reset");
  property p_data_with_sync; port_data_oe_o |-> frame_sync_oe_o[0]; endproperty
  a_data_with_sync: assert property (p_data_with_sync)
    else $error("data driven while sync one is input");
  property p_sync_order; frame_sync_oe_o inside {3'h0, 3'h1, 3'h3, 3'h7}; endproperty
  a_sync_order: assert property (p_sync_order)
    else $error("sync outputs not enabled in order");
  property p_wr_hold;
    mem_wr_valid_o && !mem_wr_ready_i |=> mem_wr_valid_o && $stable(mem_wr_data_o);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("memory word dropped while stalled");
  property p_rx_only_in; $rose(mem_wr_valid_o) |-> !port_data_oe_o; endproperty
  a_rx_only_in: assert property (p_rx_only_in)
    else $error("word captured while driving data");
endmodule
bind pvp_top pvp_top_asserts pvp_top_asserts_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_dat_o, .wb_ack_o, .frame_sync_oe_o, .port_data_oe_o, .mem_wr_valid_o, .mem_wr_data_o,
  .mem_wr_ready_i);

// ===== verification/pvp_src_model.sv
// Purpose: behavioural converter or video source on the far side
// Assumes: its clock runs only while a burst plays
// Notes:   data changes at the falling edge, half a period before sampling
`timescale 1ns/1ps
module pvp_src_model (
  // link pins
  output logic        clk_o,
  output logic [2:0]  fs_o,
  output logic [15:0] data_o
);
  logic [15:0] words[$];
  initial begin
    clk_o = 1'b0;
    fs_o = 3'h0;
    data_o = 16'h0000;
  end
  // four trailing clocks carry a driven bus that inverts on every clock
  task automatic play(input logic sync);
    for (int i = 0; i < words.size() + 4; i++) begin
      data_o = (i < words.size()) ? words[i] : ~data_o;
      fs_o[0] = sync && (i == 0);
      #100 clk_o = 1'b1;
      #100 clk_o = 1'b0;
    end
    fs_o[0] = 1'b0;
    words.delete();
  endtask
endmodule

// ===== verification/pvp_top_tb.sv
// Purpose: self-checking bench for pvp_top
// Assumes: source model plays bursts with a 200 ns port clock
// Notes:   memory side stalls every other cycle to hold words back
`timescale 1ns/1ps
module pvp_top_tb
  import pvp_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, rdy = 1'b0, rdv = 1'b0, seen = 1'b0;
  logic        hs_seen = 1'b0;
  logic        ack, wrv, rdr, dat_oe, pclk;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, rv;
  logic [2:0]  fs_o, fs_oe, fs_m, fs_w;
  logic [15:0] pd_o, pd_m, pd_w, wrd, first[3];
  logic [15:0] rdd = 16'h5A3C;
  logic [15:0] got[$];
  logic [3:0]  oe_exp[6] = '{4'h0, 4'h3, 4'hF, 4'h0, 4'h0, 4'h0};
  logic [7:0]  act[6] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h30, 8'h31};
  logic [7:0]  vs[40] = '{8'hFF, 8'h00, 8'h00, 8'hF0, 8'h01, 8'h02, 8'hFF, 8'h00, 8'h00, 8'hA0,
    8'h40, 8'h41, 8'hFF, 8'h00, 8'h00, 8'hB0, 8'hFF, 8'h00, 8'h00, 8'h80, 8'h10, 8'h11, 8'h12,
    8'h13, 8'hFF, 8'h00, 8'h00, 8'h90, 8'h20, 8'h21, 8'hFF, 8'h00, 8'h00, 8'h80, 8'h30, 8'h31,
    8'hFF, 8'h00, 8'h00, 8'h90};
  int          failures = 0, num_checks = 0;
  always #12.5 clk_i = ~clk_i;
  // shared pins resolve from the enables of pvp_top alone
  assign fs_w = (fs_oe & fs_o) | (~fs_oe & fs_m);
  assign pd_w = dat_oe ? pd_o : pd_m;
  pvp_src_model pvp_src_model_i (.clk_o(pclk), .fs_o(fs_m), .data_o(pd_m));
  pvp_top pvp_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .port_sample_clock_i(pclk), .frame_sync_i(fs_w), .frame_sync_o(fs_o),
    .frame_sync_oe_o(fs_oe), .port_data_i(pd_w), .port_data_o(pd_o), .port_data_oe_o(dat_oe),
    .mem_wr_valid_o(wrv), .mem_wr_data_o(wrd), .mem_wr_ready_i(rdy), .mem_rd_valid_i(rdv),
    .mem_rd_data_i(rdd), .mem_rd_ready_o(rdr));
  always @(posedge clk_i) begin
    rdy <= ~rdy;
    if (wrv && rdy) got.push_back(wrd);
    if (dat_oe && pd_o === rdd) seen <= 1'b1;
    if (fs_oe[0] && fs_w[0] === 1'b1) hs_seen <= 1'b1;
  end
  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      failures++;
      report_and_stop();
    end
  endtask
  task automatic wait_n(input int n);
    for (int k = 0; k < 400 && got.size() < n; k++) @(posedge clk_i);
    if (got.size() < n) begin
      failures++;
      report_and_stop();
    end
  endtask
  // 8-bit video burst: sync on field one, two active lines
  task automatic video(input logic [2:0] m, input int n);
    wb(1'b1, PVP_CTRL_OFF, 32'h0, 4'hF);
    got.delete();
    wb(1'b1, PVP_COUNT_OFF, 32'h2, 4'hF);
    wb(1'b1, PVP_CTRL_OFF, 32'h1 | (32'(m) << 1), 4'hF);
    foreach (vs[i]) pvp_src_model_i.words.push_back({8'h00, vs[i]});
    pvp_src_model_i.play(1'b0);
    wait_n(n);
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, PVP_CTRL_OFF, 32'h0, 4'hF);
    chk("ctrl reset", rv, PVP_CTRL_RST);
    wb(1'b0, PVP_DELAY_OFF, 32'h0, 4'hF);
    chk("delay reset", rv, 32'(PVP_DELAY_RST));
    wb(1'b0, 8'h1C, 32'h0, 4'hF);
    chk("unmapped", rv, 32'h0);
    wb(1'b1, PVP_COUNT_OFF, 32'h0000_1234, 4'h1);
    wb(1'b0, PVP_COUNT_OFF, 32'h0, 4'hF);
    chk("count lane", rv, 32'h34);
    $display("test registers done");
    for (int m = 0; m < 6; m++) begin
      wb(1'b1, PVP_CTRL_OFF, 32'h171 | 32'(m << 1), 4'hF);
      chk("pin dirs", {dat_oe, fs_oe}, oe_exp[m]);
    end
    rdv <= 1'b1;
    wb(1'b1, PVP_CTRL_OFF, 32'h75, 4'hF);
    chk("one sync", {dat_oe, fs_oe}, 4'h9);
    repeat (72) pvp_src_model_i.words.push_back(16'h0000);
    pvp_src_model_i.play(1'b0);
    chk("sent word", seen, 1'b1);
    chk("sync out", hs_seen, 1'b1);
    wb(1'b1, PVP_CTRL_OFF, 32'h0, 4'hF);
    rdv <= 1'b0;
    $display("test directions and output done");
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, PVP_DELAY_OFF, (k == 1) ? 32'h3 : 32'h0, 4'hF);
      wb(1'b1, PVP_COUNT_OFF, 32'h4, 4'hF);
      wb(1'b1, PVP_CTRL_OFF, (k == 2) ? 32'h1 : 32'h71, 4'hF);
      got.delete();
      for (int i = 0; i < 12; i++) pvp_src_model_i.words.push_back(16'hF0A0 + 16'(i));
      pvp_src_model_i.play(1'b1);
      wait_n(4);
      chk("in count", got.size(), 4);
      chk("in run", got[3] - got[0], 3);
      chk("in width", got[0][15:8], (k == 2) ? 8'h00 : 8'hF0);
      first[k] = got[0];
      wb(1'b1, PVP_CTRL_OFF, 32'h0, 4'hF);
    end
    chk("delay", first[1] - first[0], 3);
    $display("test input done");
    video(3'(PVP_M_ACTIVE), 6);
    chk("active count", got.size(), 6);
    for (int i = 0; i < 6; i++) chk("active word", got[i], act[i]);
    video(3'(PVP_M_FIELD), 30);
    chk("field first", got[0], 16'h40);
    chk("field code", got[2], 16'hFF);
    chk("field status", got[5], 16'hB0);
    video(3'(PVP_M_VBLANK), 2);
    chk("vbi first", got[0], 16'h40);
    chk("vbi second", got[1], 16'h41);
    $display("test video done");
    report_and_stop();
  end
endmodule
